// *** pss_regs.svh ***
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// Register byte offsets
`define PSS_ADDR_CTRL 8'h00
`define PSS_ADDR_RATIO 8'h04
`define PSS_ADDR_INNER 8'h08
`define PSS_ADDR_DWELL 8'h0C
`define PSS_ADDR_SLOW 8'h10
`define PSS_ADDR_JUMP 8'h14
`define PSS_ADDR_PULSE 8'h18
`define PSS_ADDR_LOAD 8'h1C
`define PSS_ADDR_STAT 8'h20
`define PSS_ADDR_IRQ 8'h24
`define PSS_ADDR_MASK 8'h28
// Control fields
`define PSS_CTRL_MODE_LSB 0
`define PSS_CTRL_OOS_BIT 2
`define PSS_CTRL_ZONE_LSB 3
// Reset values and ranges (ratios in percent, limits in 0.01 ohm, times in ms)
`define PSS_RATIO_DEF 8'h82
`define PSS_RATIO_MIN 8'h78
`define PSS_RATIO_MAX 8'hA0
`define PSS_INNER_DEF 16'h03E8
`define PSS_INNER_MIN 16'h000A
`define PSS_INNER_MAX 16'h4E20
`define PSS_DWELL_DEF 14'h0028
`define PSS_DWELL_MIN 14'h000A
`define PSS_DWELL_MAX 14'h03E8
`define PSS_SLOW_DEF 14'h01F4
`define PSS_SLOW_MIN 14'h0064
`define PSS_JUMP_DEF 14'h01F4
`define PSS_PULSE_DEF 14'h0096
`define PSS_PULSE_MIN 14'h0032
`define PSS_TIME_MAX 14'h2710
`define PSS_LOAD_DEF 16'hFFFF
// Timing
`define PSS_CLK_HZ 10000000
`define PSS_TICK_MS 1
`define PSS_TICK_CYC (`PSS_CLK_HZ / 1000 * `PSS_TICK_MS)
`define PSS_RESP_OKAY 2'h0
`define PSS_RESP_SLVERR 2'h2
`endif

// *** pss_pkg.sv ***
package pss_pkg;
  typedef enum logic [1:0] {
    PSS_VOTE_OFF = 2'b00,
    PSS_VOTE_ONE = 2'b01,
    PSS_VOTE_TWO = 2'b10,
    PSS_VOTE_ALL = 2'b11
  } pss_vote_e;
  typedef enum logic [1:0] {
    PSS_PH_OUT = 2'b00,
    PSS_PH_BAND = 2'b01,
    PSS_PH_INNER = 2'b10
  } pss_ph_e;
  typedef logic signed [15:0] pss_imp_t;
  typedef logic [13:0] pss_ms_t;
endpackage

// *** pss_swing.sv ***
`timescale 1ns/1ps
`include "pss_regs.svh"
// Behaviour
// - Phase voting mode selects off, one, two or all three phases, off after reset.
// - Five zone block booleans mark zones blocked during a swing, all clear after reset.
// - Outer rectangle is the inner one scaled by R and X ratios of 120 to 160 percent, default 130.
// - Inner R and X limits range 0.1 to 200 ohm in 0.01 ohm steps, default 10 ohm.
// - A phase flags a swing after staying in the band between rectangles for the dwell time.
// - Swing state is entered only when enough phases flag a swing for the voting mode.
// - Swing detection is idle while voting is off or the block input is high.
// - Swing detect output follows the swing state; very slow swing output only signals.
// - Very slow swing is flagged when impedance stays inside longer than its time, default 500 ms.
// - A jump larger than a quarter of the margin in R or X holds a jump flag for the reset time.
// - An active swing state ends when the jump flag becomes true.
// - A phase flags out of step when R has opposite signs at entry and exit.
// - Out-of-step detection resets when disabled, on a jump, or on a very slow swing.
// - Out-of-step trip issues only when enough phases flag it for the voting mode.
// - The trip output is a pulse as long as the trip pulse time, default 150 ms.
// - A load resistance below the inner R limit sets inner R to the load limit and outer R to the load limit times the R ratio.
module pss_swing (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Impedance samples, same clock domain
  input wire logic sample_stb,
  input pss_pkg::pss_imp_t r_ph [3],
  input pss_pkg::pss_imp_t x_ph [3],
  // User logic
  input wire logic swing_block_in,
  output logic swing_detect_out,
  output logic very_slow_swing_out,
  output logic out_of_step_trip_out,
  output logic [4:0] zone_swing_block_out,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  import pss_pkg::*;

  // Settings
  pss_vote_e swing_phase_vote_mode;
  logic out_of_step_enable;
  logic [4:0] zone_block;
  logic [7:0] outer_r_ratio, outer_x_ratio;
  logic [15:0] inner_r_limit, inner_x_limit, load_r_limit;
  pss_ms_t swing_dwell_time, very_slow_swing_time, jump_hold_time, trip_pulse_time;
  logic [2:0] irq_stat, irq_mask;

  // Outer limits, ratio in percent; load cut applied to inner and outer R only
  logic [23:0] r_prod, x_prod;
  assign r_prod = inner_r_limit * outer_r_ratio;
  assign x_prod = inner_x_limit * outer_x_ratio;
  wire [16:0] outer_r = 17'(r_prod / 24'd100);
  wire [16:0] outer_x = 17'(x_prod / 24'd100);
  wire load_cut = load_r_limit < inner_r_limit;
  wire [16:0] in_r_eff = load_cut ? {1'b0, load_r_limit} : {1'b0, inner_r_limit};
  wire [16:0] out_r_eff = load_cut ? 17'(({1'b0, load_r_limit} * outer_r_ratio) / 100) : outer_r;
  wire [16:0] in_x_eff = {1'b0, inner_x_limit};
  // Jump thresholds: quarter of the R margin for R, quarter of the X margin for X
  wire [16:0] marg_r = out_r_eff - in_r_eff;
  wire [16:0] marg_x = outer_x - in_x_eff;
  wire [16:0] jump_r_lim = {2'b00, marg_r[16:2]};
  wire [16:0] jump_x_lim = {2'b00, marg_x[16:2]};

  // Millisecond tick
  logic [23:0] tick_cnt;
  wire tick = tick_cnt == 24'(`PSS_TICK_CYC - 1);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) tick_cnt <= 24'h000000;
    else tick_cnt <= tick ? 24'h000000 : tick_cnt + 24'h000001;
  end

  // Per-phase geometry and state
  pss_imp_t r_prev [3], x_prev [3];
  logic [2:0] in_band, in_inner, in_any, jump_ph, swing_ph, oos_ph, entry_sign;
  // Membership as seen at the last strobe; sample lines carry junk in between
  logic [2:0] band_q, any_q;
  pss_ms_t dwell_cnt [3];
  // Gating terms the per-phase logic needs
  logic jump_flag;
  wire det_off = swing_phase_vote_mode == PSS_VOTE_OFF || swing_block_in;
  wire oos_reset = !out_of_step_enable || jump_flag || very_slow_swing_out || det_off;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      wire [16:0] ar = r_ph[g][15] ? 17'(-r_ph[g]) : {1'b0, r_ph[g]};
      wire [16:0] ax = x_ph[g][15] ? 17'(-x_ph[g]) : {1'b0, x_ph[g]};
      wire signed [16:0] dr_s = r_ph[g] - r_prev[g];
      wire signed [16:0] dx_s = x_ph[g] - x_prev[g];
      wire [16:0] dr = dr_s[16] ? 17'(-dr_s) : dr_s;
      wire [16:0] dx = dx_s[16] ? 17'(-dx_s) : dx_s;
      assign in_inner[g] = ar < in_r_eff && ax < in_x_eff;
      assign in_any[g] = ar < out_r_eff && ax < outer_x;
      assign in_band[g] = in_any[g] && !in_inner[g];
      assign jump_ph[g] = sample_stb && (dr > jump_r_lim || dx > jump_x_lim);
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          r_prev[g] <= 16'sh0000;
          x_prev[g] <= 16'sh0000;
          band_q[g] <= 1'b0;
          any_q[g] <= 1'b0;
        end else if (sample_stb) begin
          r_prev[g] <= r_ph[g];
          x_prev[g] <= x_ph[g];
          band_q[g] <= in_band[g];
          any_q[g] <= in_any[g];
        end
      end
      // Dwell timer in band; cleared while inactive or out of band
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          dwell_cnt[g] <= 14'h0000;
          swing_ph[g] <= 1'b0;
        end else if (det_off || !band_q[g]) begin
          dwell_cnt[g] <= 14'h0000;
          swing_ph[g] <= 1'b0;
        end else if (tick && dwell_cnt[g] < swing_dwell_time) begin
          dwell_cnt[g] <= dwell_cnt[g] + 14'h0001;
        end else if (dwell_cnt[g] >= swing_dwell_time) begin
          swing_ph[g] <= 1'b1;
        end
      end
      // Entry/exit sign compare of R
      logic was_in;
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          was_in <= 1'b0;
          entry_sign[g] <= 1'b0;
          oos_ph[g] <= 1'b0;
        end else if (oos_reset) begin
          was_in <= 1'b0;
          oos_ph[g] <= 1'b0;
        end else if (sample_stb) begin
          was_in <= in_any[g];
          if (in_any[g] && !was_in) entry_sign[g] <= r_ph[g][15];
          if (!in_any[g] && was_in && r_ph[g][15] != entry_sign[g]) oos_ph[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // Voting function
  function automatic logic vote_ok(input pss_vote_e m, input logic [2:0] f);
    logic [1:0] n;
    n = 2'(f[0]) + 2'(f[1]) + 2'(f[2]);
    case (m)
      PSS_VOTE_ONE: vote_ok = n >= 2'd1;
      PSS_VOTE_TWO: vote_ok = n >= 2'd2;
      PSS_VOTE_ALL: vote_ok = n == 2'd3;
      default: vote_ok = 1'b0;
    endcase
  endfunction

  wire any_jump = |jump_ph;
  pss_ms_t jump_cnt, slow_cnt, pulse_cnt;
  wire swing_vote = vote_ok(swing_phase_vote_mode, swing_ph);
  wire oos_vote = vote_ok(swing_phase_vote_mode, oos_ph);
  logic oos_vote_d;

  // Jump hold timer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      jump_flag <= 1'b0;
      jump_cnt <= 14'h0000;
    end else if (any_jump) begin
      jump_flag <= 1'b1;
      jump_cnt <= 14'h0000;
    end else if (jump_flag && tick) begin
      jump_cnt <= jump_cnt + 14'h0001;
      if (jump_cnt + 14'h0001 >= jump_hold_time) jump_flag <= 1'b0;
    end
  end

  // Swing state; a jump terminates it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) swing_detect_out <= 1'b0;
    else swing_detect_out <= swing_vote && !jump_flag && !any_jump && !det_off;
  end

  // Very slow swing: inside the outer rectangle too long
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slow_cnt <= 14'h0000;
      very_slow_swing_out <= 1'b0;
    end else if (det_off || !(|any_q)) begin
      slow_cnt <= 14'h0000;
      very_slow_swing_out <= 1'b0;
    end else begin
      if (tick && slow_cnt <= very_slow_swing_time) slow_cnt <= slow_cnt + 14'h0001;
      very_slow_swing_out <= slow_cnt > very_slow_swing_time;
    end
  end

  // Trip pulse on rising vote
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oos_vote_d <= 1'b0;
      pulse_cnt <= 14'h0000;
      out_of_step_trip_out <= 1'b0;
    end else begin
      oos_vote_d <= oos_vote;
      if (oos_vote && !oos_vote_d) begin
        out_of_step_trip_out <= 1'b1;
        pulse_cnt <= 14'h0000;
      end else if (out_of_step_trip_out && tick) begin
        pulse_cnt <= pulse_cnt + 14'h0001;
        if (pulse_cnt + 14'h0001 >= trip_pulse_time) out_of_step_trip_out <= 1'b0;
      end
    end
  end

  // Zone blocking only while swing state holds
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) zone_swing_block_out <= 5'h00;
    else zone_swing_block_out <= (swing_vote && !jump_flag && !any_jump && !det_off) ? zone_block : 5'h00;
  end

  // AXI4-Lite write path: both channels latched, either order
  logic aw_have, w_have;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire do_write = aw_have && w_have && !s_bvalid;
  wire [2:0] events = {out_of_step_trip_out, very_slow_swing_out, swing_detect_out};
  logic [2:0] events_d;
  wire [2:0] ev_rise = events & ~events_d;
  wire [2:0] w1c = (do_write && w_strb != 4'h0 && aw_addr == `PSS_ADDR_IRQ) ? w_data[2:0] : 3'h0;
  wire wr_ok = aw_addr <= `PSS_ADDR_MASK && aw_addr[1:0] == 2'h0 && aw_addr != `PSS_ADDR_STAT;
  // Clamp a setting into its range
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp = v < lo ? lo : (v > hi ? hi : v);
  endfunction

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= `PSS_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb; // Strobes must travel with their data
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
      end else if (s_bvalid && s_bready) s_bvalid <= 1'b0;
    end
  end
  assign s_awready = !aw_have && !s_bvalid;
  assign s_wready = !w_have && !s_bvalid;

  // Settings registers; out-of-range writes clamp
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      swing_phase_vote_mode <= PSS_VOTE_OFF;
      out_of_step_enable <= 1'b0;
      zone_block <= 5'h00;
      outer_r_ratio <= `PSS_RATIO_DEF;
      outer_x_ratio <= `PSS_RATIO_DEF;
      inner_r_limit <= `PSS_INNER_DEF;
      inner_x_limit <= `PSS_INNER_DEF;
      swing_dwell_time <= `PSS_DWELL_DEF;
      very_slow_swing_time <= `PSS_SLOW_DEF;
      jump_hold_time <= `PSS_JUMP_DEF;
      trip_pulse_time <= `PSS_PULSE_DEF;
      load_r_limit <= `PSS_LOAD_DEF;
      irq_mask <= 3'h0;
    end else if (do_write && w_strb != 4'h0) begin
      case (aw_addr)
        `PSS_ADDR_CTRL: begin
          swing_phase_vote_mode <= pss_vote_e'(w_data[`PSS_CTRL_MODE_LSB +: 2]);
          out_of_step_enable <= w_data[`PSS_CTRL_OOS_BIT];
          zone_block <= w_data[`PSS_CTRL_ZONE_LSB +: 5];
        end
        `PSS_ADDR_RATIO: begin
          outer_r_ratio <= 8'(clamp({8'h00, w_data[7:0]}, {8'h00, `PSS_RATIO_MIN}, {8'h00, `PSS_RATIO_MAX}));
          outer_x_ratio <= 8'(clamp({8'h00, w_data[15:8]}, {8'h00, `PSS_RATIO_MIN}, {8'h00, `PSS_RATIO_MAX}));
        end
        `PSS_ADDR_INNER: begin
          inner_r_limit <= clamp(w_data[15:0], `PSS_INNER_MIN, `PSS_INNER_MAX);
          inner_x_limit <= clamp(w_data[31:16], `PSS_INNER_MIN, `PSS_INNER_MAX);
        end
        `PSS_ADDR_DWELL: swing_dwell_time <= 14'(clamp({2'b00, w_data[13:0]}, {2'b00, `PSS_DWELL_MIN}, {2'b00, `PSS_DWELL_MAX}));
        `PSS_ADDR_SLOW: very_slow_swing_time <= 14'(clamp({2'b00, w_data[13:0]}, {2'b00, `PSS_SLOW_MIN}, {2'b00, `PSS_TIME_MAX}));
        `PSS_ADDR_JUMP: jump_hold_time <= 14'(clamp({2'b00, w_data[13:0]}, {2'b00, `PSS_SLOW_MIN}, {2'b00, `PSS_TIME_MAX}));
        `PSS_ADDR_PULSE: trip_pulse_time <= 14'(clamp({2'b00, w_data[13:0]}, {2'b00, `PSS_PULSE_MIN}, {2'b00, `PSS_TIME_MAX}));
        `PSS_ADDR_LOAD: load_r_limit <= w_data[15:0];
        `PSS_ADDR_MASK: irq_mask <= w_data[2:0];
        default: ;
      endcase
    end
  end

  // Sticky event status; a new event wins over the clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      events_d <= 3'h0;
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end else begin
      events_d <= events;
      irq_stat <= (irq_stat & ~w1c) | ev_rise;
      irq <= |(((irq_stat & ~w1c) | ev_rise) & ~irq_mask); // A set mask bit hides its event
    end
  end

  // AXI4-Lite read path
  wire [31:0] rd_mux =
    s_araddr == `PSS_ADDR_CTRL ? {24'h000000, zone_block, out_of_step_enable, swing_phase_vote_mode} :
    s_araddr == `PSS_ADDR_RATIO ? {16'h0000, outer_x_ratio, outer_r_ratio} :
    s_araddr == `PSS_ADDR_INNER ? {inner_x_limit, inner_r_limit} :
    s_araddr == `PSS_ADDR_DWELL ? {18'h00000, swing_dwell_time} :
    s_araddr == `PSS_ADDR_SLOW ? {18'h00000, very_slow_swing_time} :
    s_araddr == `PSS_ADDR_JUMP ? {18'h00000, jump_hold_time} :
    s_araddr == `PSS_ADDR_PULSE ? {18'h00000, trip_pulse_time} :
    s_araddr == `PSS_ADDR_LOAD ? {16'h0000, load_r_limit} :
    s_araddr == `PSS_ADDR_STAT ? {22'h000000, oos_ph, swing_ph, jump_flag, events} :
    s_araddr == `PSS_ADDR_IRQ ? {29'h00000000, irq_stat} :
    s_araddr == `PSS_ADDR_MASK ? {29'h00000000, irq_mask} : 32'h00000000;
  wire rd_ok = s_araddr <= `PSS_ADDR_MASK && s_araddr[1:0] == 2'h0;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= `PSS_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_mux;
      s_rresp <= rd_ok ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
    end else if (s_rvalid && s_rready) s_rvalid <= 1'b0;
  end
  assign s_arready = !s_rvalid;

  // Checks
  a_off_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(det_off) |-> !swing_detect_out) else $error("swing detect while inactive");
  a_jump_ends: assert property (@(posedge core_clk) disable iff (!rst_b)
    any_jump |=> !swing_detect_out) else $error("swing not ended by jump");
  a_trip_vote: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(out_of_step_trip_out) |-> $past(oos_vote)) else $error("trip without vote");
  a_oos_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(oos_reset) |-> oos_ph == 3'h0) else $error("oos flag survived reset");
  a_swing_vote: assert property (@(posedge core_clk) disable iff (!rst_b)
    swing_detect_out |-> $past(swing_vote)) else $error("swing without vote");
  a_slow_time: assert property (@(posedge core_clk) disable iff (!rst_b)
    very_slow_swing_out |-> slow_cnt > very_slow_swing_time) else $error("early slow swing");
  a_dwell_min: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(swing_ph[0]) |-> dwell_cnt[0] >= swing_dwell_time) else $error("early phase swing");
  a_jump_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    any_jump |=> jump_flag) else $error("jump flag not set");
  a_zone_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    !swing_detect_out |-> zone_swing_block_out == 5'h00) else $error("zone blocked outside swing");
endmodule

// *** pss_imp_src.sv ***
`timescale 1ns/1ps
// Stand-in for the impedance measurement path feeding the swing block
module pss_imp_src #(
  parameter int SAMPLE_CYC = 100
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Impedance the bench wants measured
  input pss_pkg::pss_imp_t r_set [3],
  input pss_pkg::pss_imp_t x_set [3],
  // Sample stream toward the block
  output logic sample_stb,
  output pss_pkg::pss_imp_t r_ph [3],
  output pss_pkg::pss_imp_t x_ph [3]
);
  import pss_pkg::*;
  int cnt;
  logic fire;
  assign fire = (cnt == SAMPLE_CYC - 1);
  // One strobe per period; data flips between strobes so stale values never pass as valid
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      sample_stb <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        r_ph[i] <= '0;
        x_ph[i] <= '0;
      end
    end else begin
      cnt <= fire ? 0 : cnt + 1;
      sample_stb <= fire;
      for (int i = 0; i < 3; i++) begin
        r_ph[i] <= fire ? r_set[i] : ~r_ph[i];
        x_ph[i] <= fire ? x_set[i] : ~x_ph[i];
      end
    end
  end
endmodule

// *** pss_swing_tb_top.sv ***
`timescale 1ns/1ps
`include "pss_regs.svh"
module pss_swing_tb_top;
  import pss_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic swing_block_in = 1'b0;
  pss_imp_t r_set [3];
  pss_imp_t x_set [3];
  pss_imp_t r_ph [3];
  pss_imp_t x_ph [3];
  logic sample_stb, swing_detect_out, very_slow_swing_out, out_of_step_trip_out, irq;
  logic [4:0] zone_swing_block_out;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int t;
  // Reset value table, mapped registers other than status, in address order
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h28};
  logic [31:0] rv [10] = '{32'h0, 32'h8282, 32'h03E803E8, 32'h28, 32'h1F4, 32'h1F4, 32'h96, 32'hFFFF, 32'h0, 32'h0};
  // Out-of-range writes and the clamped value read back
  logic [7:0] ca [6] = '{8'h04, 8'h08, 8'h0C, 8'h0C, 8'h10, 8'h18};
  logic [31:0] cw [6] = '{32'h00FF, 32'h0005FFFF, 32'hBB8, 32'h5, 32'h3000, 32'h1};
  logic [31:0] ce [6] = '{32'h78A0, 32'h000A4E20, 32'h3E8, 32'hA, 32'h2710, 32'h32};

  always #50 core_clk = ~core_clk;

  pss_imp_src src_u (
    .core_clk(core_clk), .rst_b(rst_b), .r_set(r_set), .x_set(x_set),
    .sample_stb(sample_stb), .r_ph(r_ph), .x_ph(x_ph)
  );

  pss_swing dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .sample_stb(sample_stb), .r_ph(r_ph), .x_ph(x_ph),
    .swing_block_in(swing_block_in), .swing_detect_out(swing_detect_out),
    .very_slow_swing_out(very_slow_swing_out), .out_of_step_trip_out(out_of_step_trip_out),
    .zone_swing_block_out(zone_swing_block_out), .irq(irq),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready)
  );

  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge core_clk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(ah && wh)) begin
      @(posedge core_clk);
      if (s_awready && !ah) begin
        ah = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wready && !wh) begin
        wh = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_bvalid);
    s_bready <= 1'b0;
    chk(s_bresp, er);
  endtask

  // Read: compare under a mask so status bits can be checked alone
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    @(posedge core_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge core_clk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_rvalid);
    s_rready <= 1'b0;
    chk(s_rdata & m, e & m);
    chk(s_rresp, er);
  endtask

  // Walk one phase's R a half ohm per sample, below the jump threshold
  task ramp(input int p, input pss_imp_t to);
    repeat (100) @(posedge core_clk);
    while (r_set[p] != to) begin
      r_set[p] <= r_set[p] < to ? r_set[p] + 16'sd50 : r_set[p] - 16'sd50;
      repeat (100) @(posedge core_clk);
    end
  endtask

  // Hang guard, well above the dwell wait
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 150000) begin
      n_errors++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    for (int i = 0; i < 3; i++) begin
      r_set[i] = 16'sd0;
      x_set[i] = 16'sd0;
    end
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i], 32'hFFFFFFFF, 2'h0);
    rd(8'h40, 32'h0, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    rd(8'h02, 32'h0, 32'h0, 2'h2);
    wr(8'h20, 32'h3FF, 2'h2);
    for (int i = 0; i < 6; i++) begin
      wr(ca[i], cw[i], 2'h0);
      rd(ca[i], ce[i], 32'hFFFFFFFF, 2'h0);
    end
    wr(8'h04, 32'h8282, 2'h0);
    wr(8'h08, 32'h03E803E8, 2'h0);
    // One of three voting, out of step on, zones 1, 3 and 5 blocked
    wr(8'h00, 32'hAD, 2'h0);
    rd(8'h00, 32'hAD, 32'hFF, 2'h0);
    // Phase 1 walks into the band: outside 10 ohm, inside 13 ohm
    ramp(1, 16'sd1150);
    repeat (85000) @(posedge core_clk);
    chk(swing_detect_out, 32'h0);
    t = 0;
    while (swing_detect_out !== 1'b1 && t < 30000) begin
      @(posedge core_clk);
      t++;
    end
    chk(swing_detect_out, 32'h1);
    chk(zone_swing_block_out, 32'h15);
    chk(very_slow_swing_out, 32'h0);
    chk(out_of_step_trip_out, 32'h0);
    // Swing event latched, then masked, unmasked and cleared
    rd(8'h24, 32'h1, 32'h1, 2'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 32'h1);
    wr(8'h28, 32'h1, 2'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 32'h0);
    wr(8'h28, 32'h0, 2'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 32'h1);
    wr(8'h24, 32'h1, 2'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 32'h0);
    // Phase 0 leaves on the side it entered: no out of step
    ramp(0, 16'sd1400);
    chk(out_of_step_trip_out, 32'h0);
    // Phase 0 re-enters with R positive and leaves with R negative
    ramp(0, -16'sd1400);
    chk(out_of_step_trip_out, 32'h1);
    chk(swing_detect_out, 32'h1);
    rd(8'h24, 32'h4, 32'h4, 2'h0);
    // Jump far beyond a quarter margin must end the swing
    @(posedge core_clk);
    r_set[1] <= 16'sd3000;
    t = 0;
    while (swing_detect_out !== 1'b0 && t < 400) begin
      @(posedge core_clk);
      t++;
    end
    chk(swing_detect_out, 32'h0);
    chk(zone_swing_block_out, 32'h0);
    chk(out_of_step_trip_out, 32'h1);
    rd(8'h20, 32'h8, 32'h388, 2'h0);
    test_done();
  end
endmodule
